/* File: hdl/pec_pkg.sv */
package pec_pkg;

    localparam int unsigned NUM_CH   = 2;
    localparam int unsigned CNT_W    = 48;
    localparam int unsigned ADDR_W   = 8;
    localparam int unsigned STEP_W   = 5;

    // apb register map, byte addresses
    localparam logic [ADDR_W-1:0] OFS_CTRL    = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_CMD     = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_STATUS  = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_CNT0_LO = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_CNT0_HI = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_CNT1_LO = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_CNT1_HI = 8'h18;

    // ctrl field layout, one byte per channel
    localparam int unsigned CTRL_CH_STRIDE = 8;
    localparam int unsigned CTRL_SEL_LSB   = 0;
    localparam int unsigned CTRL_RANGE_BIT = 5;
    localparam int unsigned CTRL_RATIO_BIT = 6;
    localparam int unsigned CMD_CLEAR_BIT  = 0;
    localparam int unsigned STAT_OVF_LSB   = 0;
    localparam int unsigned STAT_WIN_LSB   = 4;
    localparam int unsigned HI_W           = CNT_W - 32;
    localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;

    // bus-to-cpu clock ratio codes and their steps
    localparam logic [STEP_W-1:0] STEP_ONE = 5'h01;
    localparam logic [STEP_W-1:0] STEP_R3  = 5'h03;
    localparam logic [STEP_W-1:0] STEP_R4  = 5'h04;
    localparam logic [STEP_W-1:0] STEP_R6  = 5'h06;
    localparam logic [STEP_W-1:0] STEP_R8  = 5'h08;
    localparam logic [STEP_W-1:0] STEP_R12 = 5'h0C;
    localparam logic [STEP_W-1:0] STEP_R24 = 5'h18;

    typedef enum logic [4:0] {
        EV_CACHEABLE_READ,
        EV_CACHEABLE_WRITE,
        EV_CACHEABLE_RW,
        EV_LOCAL_RAM,
        EV_ALL_OPERAND,
        EV_ONCHIP_IO,
        EV_DCACHE_READ_MISS,
        EV_DCACHE_WRITE_MISS,
        EV_DCACHE_ANY_MISS,
        EV_ICACHE_MISS,
        EV_DATA_XLATE_MISS,
        EV_FETCH_XLATE_MISS,
        EV_CACHEABLE_FETCH,
        EV_ANY_FETCH,
        EV_BRANCH_ISSUE,
        EV_BRANCH_TAKEN,
        EV_SUBROUTINE_CALL,
        EV_INSTR_ISSUE,
        EV_DUAL_ISSUE,
        EV_FLOAT_ISSUE,
        EV_TRAP_INSTR,
        EV_IRQ,
        EV_NMI,
        EV_BREAK_A,
        EV_BREAK_B,
        EV_ICACHE_FILL,
        EV_DCACHE_FILL,
        EV_ELAPSED,
        EV_FREEZE_ICACHE,
        EV_FREEZE_DCACHE,
        EV_FREEZE_BRANCH
    } pec_event_t;

    typedef enum logic [2:0] {
        RATIO_3,
        RATIO_4,
        RATIO_6,
        RATIO_8,
        RATIO_12,
        RATIO_24
    } pec_ratio_t;

    // per-cycle event strobes from the core
    typedef struct packed {
        logic       cacheable_read;
        logic       cacheable_write;
        logic       local_ram_access;
        logic       operand_access;
        logic       onchip_io_access;
        logic       dcache_read_miss;
        logic       dcache_write_miss;
        logic       icache_miss;
        logic       data_xlate_miss;
        logic       fetch_xlate_miss;
        logic       cacheable_fetch;
        logic       any_fetch;
        logic       branch_issue;
        logic       branch_taken;
        logic       subroutine_call;
        logic [1:0] issue_num;
        logic       float_issue;
        logic       trap_instr;
        logic       irq_accept;
        logic       nmi_accept;
        logic       break_a_hit;
        logic       break_b_hit;
        logic       icache_fill;
        logic       dcache_fill;
        logic       freeze_icache;
        logic       freeze_dcache;
        logic       freeze_branch;
    } pec_events_t;

    // run state and break-condition matches
    typedef struct packed {
        logic       program_running;
        logic       brk1_match;
        logic       brk4_match;
        pec_ratio_t ratio;
    } pec_run_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0] pwdata;
    } pec_apb_req_t;

endpackage : pec_pkg

/* File: hdl/pec_top.sv */
// Behaviour
// - two independent channels, each with its own event select.
// - range one counts only while the user program runs.
// - range two opens on break condition 1, closes on condition 4.
// - in range two, conditions 1 and 4 gate counting, never halt.
// - cacheable operand accesses: read, write, or both variants.
// - local ram accesses, and all operand accesses, separately.
// - one count per on-chip io access.
// - operand cache misses on read, on write, or either.
// - one count per instruction cache miss.
// - data translation misses and fetch translation misses, separately.
// - cacheable fetches, and all fetches, separately.
// - issued branches, excluding zero-displacement conditionals (core flags).
// - taken branches from the same branch set.
// - issued subroutine calls, relative and register forms.
// - instructions issued, and dual-issue cycles, separately.
// - floating-point issues, and software trap executions, separately.
// - accepted non-nmi interrupts, and nmi interrupts, separately.
// - break channel a hits and channel b hits, separately.
// - instruction and operand cache fill cycles, one or a ratio step per cycle.
// - elapsed selection adds one, or the ratio step, per cycle inside the range.
// - freeze cycles for icache miss, dcache miss or branch.
// - 48-bit counters; overflow marks the count invalid.
// - cycle events add one, or a ratio step of 3..24.
module pec_top
    import pec_pkg::*;
#(
    parameter int unsigned CH_NUM  = pec_pkg::NUM_CH,
    parameter int unsigned CNT_WID = pec_pkg::CNT_W
) (
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [pec_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]               pwdata,
    input  wire logic [3:0]                pstrb,
    output logic                           pready,
    output logic [31:0]                    prdata,
    output logic                           pslverr,
    input  wire pec_pkg::pec_events_t      events,
    input  wire pec_pkg::pec_run_t         run,
    output logic                           brk_halt_inhibit
);
    import pec_pkg::*;

    if (CH_NUM != 2 || CNT_WID != 48) begin : g_bad_cfg
        $error("pec_top: register map serves two 48-bit channels only");
    end

    function automatic logic [STEP_W-1:0] ratio_step(input pec_ratio_t r);
        case (r)
            RATIO_3:  ratio_step = STEP_R3;
            RATIO_4:  ratio_step = STEP_R4;
            RATIO_6:  ratio_step = STEP_R6;
            RATIO_8:  ratio_step = STEP_R8;
            RATIO_12: ratio_step = STEP_R12;
            RATIO_24: ratio_step = STEP_R24;
            default:  ratio_step = STEP_R24;
        endcase
    endfunction

    // increment for one channel in one cycle
    function automatic logic [STEP_W-1:0] ev_incr(input pec_event_t sel,
                                                  input pec_events_t e,
                                                  input logic [STEP_W-1:0] cyc);
        logic hit;
        logic is_cyc;
        hit    = 1'b0;
        is_cyc = 1'b0;
        ev_incr = '0;
        case (sel)
            EV_CACHEABLE_READ:    hit = e.cacheable_read;
            EV_CACHEABLE_WRITE:   hit = e.cacheable_write;
            EV_CACHEABLE_RW:      hit = e.cacheable_read | e.cacheable_write;
            EV_LOCAL_RAM:         hit = e.local_ram_access;
            EV_ALL_OPERAND:       hit = e.operand_access;
            EV_ONCHIP_IO:         hit = e.onchip_io_access;
            EV_DCACHE_READ_MISS:  hit = e.dcache_read_miss;
            EV_DCACHE_WRITE_MISS: hit = e.dcache_write_miss;
            EV_DCACHE_ANY_MISS:   hit = e.dcache_read_miss | e.dcache_write_miss;
            EV_ICACHE_MISS:       hit = e.icache_miss;
            EV_DATA_XLATE_MISS:   hit = e.data_xlate_miss;
            EV_FETCH_XLATE_MISS:  hit = e.fetch_xlate_miss;
            EV_CACHEABLE_FETCH:   hit = e.cacheable_fetch;
            EV_ANY_FETCH:         hit = e.any_fetch;
            EV_BRANCH_ISSUE:      hit = e.branch_issue;
            EV_BRANCH_TAKEN:      hit = e.branch_taken;
            EV_SUBROUTINE_CALL:   hit = e.subroutine_call;
            EV_DUAL_ISSUE:        hit = (e.issue_num == 2'h2);
            EV_FLOAT_ISSUE:       hit = e.float_issue;
            EV_TRAP_INSTR:        hit = e.trap_instr;
            EV_IRQ:               hit = e.irq_accept;
            EV_NMI:               hit = e.nmi_accept;
            EV_BREAK_A:           hit = e.break_a_hit;
            EV_BREAK_B:           hit = e.break_b_hit;
            EV_ICACHE_FILL:       is_cyc = e.icache_fill;
            EV_DCACHE_FILL:       is_cyc = e.dcache_fill;
            EV_ELAPSED:           is_cyc = 1'b1;
            EV_FREEZE_ICACHE:     is_cyc = e.freeze_icache;
            EV_FREEZE_DCACHE:     is_cyc = e.freeze_dcache;
            EV_FREEZE_BRANCH:     is_cyc = e.freeze_branch;
            default:              hit = 1'b0;
        endcase
        // issue count is the one event that may add two in a cycle
        if (sel == EV_INSTR_ISSUE) begin
            ev_incr = STEP_W'(e.issue_num);
        end else if (is_cyc) begin
            ev_incr = cyc;
        end else if (hit) begin
            ev_incr = STEP_ONE;
        end
    endfunction

    logic [31:0]         ctrl_q;
    logic [CH_NUM-1:0]   win_q;
    logic [CH_NUM-1:0]   ovf_q;
    logic [CNT_WID-1:0]  cnt_q [CH_NUM];
    logic                pready_q;
    logic [31:0]         prdata_q;
    logic                pslverr_q;
    logic                inhibit_q;

    logic                acc;
    logic                wr_en;
    logic                clr;
    logic                addr_ok;
    logic [31:0]         rd_d;
    logic [CH_NUM-1:0]   range2;

    // one wait state: answer on the second access cycle, from a flop
    assign acc   = psel & penable & ~pready_q;
    assign wr_en = acc & pwrite & addr_ok;
    assign clr   = wr_en && paddr == OFS_CMD && pstrb[0] && pwdata[CMD_CLEAR_BIT];

    always_comb begin
        addr_ok = 1'b1;
        rd_d    = '0;
        case (paddr)
            OFS_CTRL:    rd_d = ctrl_q;
            OFS_CMD:     rd_d = '0;
            OFS_STATUS: begin
                rd_d[STAT_OVF_LSB +: CH_NUM] = ovf_q;
                rd_d[STAT_WIN_LSB +: CH_NUM] = win_q;
            end
            OFS_CNT0_LO: rd_d = cnt_q[0][31:0];
            OFS_CNT0_HI: rd_d[HI_W-1:0] = cnt_q[0][CNT_WID-1:32];
            OFS_CNT1_LO: rd_d = cnt_q[1][31:0];
            OFS_CNT1_HI: rd_d[HI_W-1:0] = cnt_q[1][CNT_WID-1:32];
            default:     addr_ok = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            prdata_q  <= '0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q  <= acc;
            pslverr_q <= acc & ~addr_ok;
            prdata_q  <= (acc && !pwrite && addr_ok) ? rd_d : '0;
        end
    end

    // selection and range are written by the host before the run
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= CTRL_RESET;
        end else if (wr_en && paddr == OFS_CTRL) begin
            for (int b = 0; b < 4; b++) begin
                if (pstrb[b]) begin
                    ctrl_q[b*8 +: 8] <= pwdata[b*8 +: 8];
                end
            end
        end
    end

    // counter and window updates land on the edge that raises pready, one edge
    // before the master sees it, so the write is visible by then: use acc
    generate
        for (genvar c = 0; c < CH_NUM; c++) begin : g_ch
            pec_event_t        sel;
            logic              ratio_mode;
            logic              active;
            logic [STEP_W-1:0] cyc_step;
            logic [CNT_WID:0]  sum;

            assign sel        = pec_event_t'(ctrl_q[c*CTRL_CH_STRIDE + CTRL_SEL_LSB +: 5]);
            assign range2[c]  = ctrl_q[c*CTRL_CH_STRIDE + CTRL_RANGE_BIT];
            assign ratio_mode = ctrl_q[c*CTRL_CH_STRIDE + CTRL_RATIO_BIT];
            assign cyc_step   = ratio_mode ? ratio_step(run.ratio) : STEP_ONE;
            // range two also needs the program running, so halts stop it
            assign active     = run.program_running & (range2[c] ? win_q[c] : 1'b1);
            assign sum        = {1'b0, cnt_q[c]}
                              + (CNT_WID+1)'(ev_incr(sel, events, cyc_step));

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    win_q[c] <= 1'b0;
                end else if (clr || !range2[c]) begin
                    win_q[c] <= 1'b0;
                end else if (run.brk4_match) begin
                    win_q[c] <= 1'b0;
                end else if (run.brk1_match) begin
                    win_q[c] <= 1'b1;
                end
            end

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    cnt_q[c] <= '0;
                end else if (clr) begin
                    cnt_q[c] <= '0;
                end else if (active) begin
                    cnt_q[c] <= sum[CNT_WID-1:0];
                end
            end

            // sticky invalid flag; a wrap in the clearing cycle is dropped
            // because the count itself restarts from zero
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    ovf_q[c] <= 1'b0;
                end else if (clr) begin
                    ovf_q[c] <= 1'b0;
                end else if (active && sum[CNT_WID]) begin
                    ovf_q[c] <= 1'b1;
                end
            end
        end
    endgenerate

    // core must not halt on conditions 1 and 4 while any channel uses them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            inhibit_q <= 1'b0;
        end else begin
            inhibit_q <= |range2;
        end
    end

    assign pready           = pready_q;
    assign prdata           = prdata_q;
    assign pslverr          = pslverr_q;
    assign brk_halt_inhibit = inhibit_q;

endmodule // pec_top

/* File: tb/pec_checker.sv */
module pec_checker
    import pec_pkg::*;
#(
    parameter int unsigned CH_NUM  = pec_pkg::NUM_CH,
    parameter int unsigned CNT_WID = pec_pkg::CNT_W
) (
    input wire logic                       pclk,
    input wire logic                       presetn,
    input wire logic                       psel,
    input wire logic                       penable,
    input wire logic                       pwrite,
    input wire logic [pec_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0]                pwdata,
    input wire logic [3:0]                 pstrb,
    input wire logic                       pready,
    input wire logic [31:0]                prdata,
    input wire logic                       pslverr,
    input wire pec_pkg::pec_events_t       events,
    input wire pec_pkg::pec_run_t          run,
    input wire logic                       brk_halt_inhibit
);
    import pec_pkg::*;

    logic [2:0] ctrl_wr_q;

    // inhibit may lag the ctrl write by a couple of edges
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            ctrl_wr_q <= 3'h0;
        else
            ctrl_wr_q <= {ctrl_wr_q[1:0], psel && pwrite && paddr == OFS_CTRL};
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_READY_SECOND: assert property (psel && penable && !pready |=> pready)
        else $error("no ready in second access cycle");
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    AST_READY_ACCESS: assert property (pready |-> psel && penable && $past(penable))
        else $error("ready outside access phase");
    AST_UNMAPPED_ERR: assert property (pready && paddr > OFS_CNT1_HI |-> pslverr)
        else $error("unmapped access without error");
    AST_MAPPED_OK: assert property (pready && paddr <= OFS_CNT1_HI && paddr[1:0] == 2'h0
        |-> !pslverr)
        else $error("error on mapped access");
    AST_ERR_NO_DATA: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error without ready or with data");
    AST_IDLE_DATA: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside answer cycle");
    AST_CMD_READ: assert property (pready && !pwrite && paddr == OFS_CMD |-> prdata == 32'h0)
        else $error("command register not read as zero");
    AST_INHIBIT_CAUSE: assert property ($changed(brk_halt_inhibit) |-> ctrl_wr_q != 3'h0)
        else $error("halt inhibit moved without ctrl write");
    AST_INHIBIT_SET: assert property (pready && pwrite && paddr == OFS_CTRL && pstrb == 4'hF
        && (pwdata[5] || pwdata[13]) |-> ##[0:2] brk_halt_inhibit)
        else $error("halt inhibit not raised for range two");
endmodule // pec_checker

bind pec_top pec_checker #(.CH_NUM(CH_NUM), .CNT_WID(CNT_WID)) u_pec_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .events(events), .run(run), .brk_halt_inhibit(brk_halt_inhibit)
);

/* File: tb/tb.sv */
module tb import pec_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;

    logic              pclk    = 1'b0;
    logic              presetn = 1'b0;
    logic              psel    = 1'b0;
    logic              penable = 1'b0;
    logic              pwrite  = 1'b0;
    logic [ADDR_W-1:0] paddr   = 8'h00;
    logic [31:0]       pwdata  = 32'h0;
    logic [3:0]        pstrb   = 4'hF;
    logic              pready, pslverr, brk_halt_inhibit, rerr;
    logic [31:0]       prdata, rdat;
    pec_events_t       events  = '0;
    pec_run_t          run     = '0;
    int                fails   = 0;
    int                n_tests = 0;
    longint            m_cnt [2] = '{0, 0};
    int                m_code [2];
    bit                m_rng [2], m_rb [2], m_win [2];

    pec_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .events(events), .run(run),
        .brk_halt_inhibit(brk_halt_inhibit));

    always #12.5 pclk = ~pclk;

    // reference increment of one channel for one cycle
    function automatic longint inc(int code, bit rb, pec_events_t e, logic [2:0] ra);
        logic [30:0] s;
        int          st;
        st = !rb ? 1 : (ra == 3'h0) ? 3 : (ra == 3'h1) ? 4 : (ra == 3'h2) ? 6 : 24;
        if (rb && ra == 3'h3) st = 8;
        if (rb && ra == 3'h4) st = 12;
        s = {e.freeze_branch, e.freeze_dcache, e.freeze_icache, 1'b1, e.dcache_fill,
             e.icache_fill, e.break_b_hit, e.break_a_hit, e.nmi_accept, e.irq_accept,
             e.trap_instr, e.float_issue, e.issue_num == 2'h2, e.issue_num != 2'h0,
             e.subroutine_call, e.branch_taken, e.branch_issue, e.any_fetch,
             e.cacheable_fetch, e.fetch_xlate_miss, e.data_xlate_miss, e.icache_miss,
             e.dcache_read_miss | e.dcache_write_miss, e.dcache_write_miss,
             e.dcache_read_miss, e.onchip_io_access, e.operand_access, e.local_ram_access,
             e.cacheable_read | e.cacheable_write, e.cacheable_write, e.cacheable_read};
        if (code > 30 || !s[code]) return 0;
        if (code == EV_INSTR_ISSUE) return e.issue_num;
        if (code >= EV_ICACHE_FILL) return st;
        return 1;
    endfunction

    always @(posedge pclk) begin
        for (int c = 0; c < 2; c++) begin
            if (run.program_running && (!m_rng[c] || m_win[c]))
                m_cnt[c] = (m_cnt[c] + inc(m_code[c], m_rb[c], events, run.ratio))
                    & 64'h0000_FFFF_FFFF_FFFF;
            if (run.brk4_match)
                m_win[c] = 1'b0;
            else if (run.brk1_match)
                m_win[c] = 1'b1;
        end
    end

    task automatic complete_run();
        if (fails == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one idle cycle after each transfer keeps strobes from being driven twice at an edge
    task automatic xfer(input bit wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            fails++;
            complete_run();
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic e);
        xfer(1'b0, a, 32'h0);
        chk(rdat, d);
        chk({31'h0, rerr}, {31'h0, e});
    endtask

    initial begin
        repeat (100000) @(posedge pclk);
        fails++;
        complete_run();
    end

    initial begin
        logic [31:0] cv, rv;
        pec_events_t ev;
        void'($urandom(62));
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int a = 0; a <= 8'h18; a += 4)
            rd(8'(a), 32'h0, 1'b0);
        rd(8'h1C, 32'h0, 1'b1);
        rd(8'hFC, 32'h0, 1'b1);
        xfer(1'b1, 8'h1C, 32'hFFFF_FFFF);
        chk({31'h0, rerr}, 32'h1);
        xfer(1'b1, OFS_STATUS, 32'hFFFF_FFFF);
        xfer(1'b1, OFS_CNT0_LO, 32'hFFFF_FFFF);
        rd(OFS_STATUS, 32'h0, 1'b0);
        rd(OFS_CNT0_LO, 32'h0, 1'b0);
        // only the low ctrl byte is enabled, the rest must keep its reset value
        pstrb <= 4'h1;
        xfer(1'b1, OFS_CTRL, 32'h0000_2121);
        pstrb <= 4'hF;
        rd(OFS_CTRL, 32'h0000_0021, 1'b0);
        for (int k = 0; k < 31; k++) begin
            m_code[0] = k;
            m_code[1] = 30 - k;
            for (int c = 0; c < 2; c++) begin
                m_rng[c] = 1'($urandom_range(0, 1));
                m_rb[c] = 1'($urandom_range(0, 1));
            end
            cv = {17'h0, m_rb[1], m_rng[1], 5'(m_code[1]), 1'b0, m_rb[0], m_rng[0],
                  5'(m_code[0])};
            xfer(1'b1, OFS_CTRL, cv);
            rd(OFS_CTRL, cv, 1'b0);
            chk({31'h0, brk_halt_inhibit}, {31'h0, m_rng[0] | m_rng[1]});
            xfer(1'b1, OFS_CMD, 32'h1);
            m_cnt = '{0, 0};
            m_win = '{0, 0};
            run.ratio <= pec_ratio_t'(3'($urandom_range(0, 7)));
            repeat (40) begin
                rv = $urandom;
                ev = rv[$bits(pec_events_t)-1:0];
                if (ev.issue_num == 2'h3) ev.issue_num = 2'h2;
                events <= ev;
                run.program_running <= ($urandom_range(0, 3) != 0);
                run.brk1_match <= ($urandom_range(0, 7) == 0);
                run.brk4_match <= ($urandom_range(0, 7) == 0);
                @(posedge pclk);
            end
            events <= '0;
            run <= '0;
            repeat (2) @(posedge pclk);
            for (int c = 0; c < 2; c++) begin
                rd(c ? OFS_CNT1_LO : OFS_CNT0_LO, m_cnt[c][31:0], 1'b0);
                rd(c ? OFS_CNT1_HI : OFS_CNT0_HI, {16'h0, m_cnt[c][47:32]}, 1'b0);
            end
            xfer(1'b0, OFS_STATUS, 32'h0);
            chk(rdat, {26'h0, m_rng[1] & m_win[1], m_rng[0] & m_win[0], 4'h0});
        end
        complete_run();
    end
endmodule // tb
